// file: rtl/hub_boot_sequencer.v
// Boot and configuration stage sequencer of the hub controller.
// Assumes the serial-bus slave, OTP and USB core share this clock;
// straps, PLL lock, VBUS and slave bus pins are asynchronous.
// Contract
// - Reset low holds standby, everything off.
// - Reset high runs hub boot stages.
// - Every configuration value reloaded after standby.
// - First stage resets, waits PLL, loads defaults.
// - Probe flash signature at 0xFFFA, run 0x0000.
// - No signature: continue from ROM defaults stage.
// - No SPI strap: skip flash, use ROM.
// - Single/dual flash, clock modes 0 and 3.
// - ROM stage loads all default settings.
// - Straps override defaults in strap stage.
// - Configuration 5 goes to pull-up probe.
// - Both pull-ups present: slave, host configuration.
// - Host configuration waits forever for master.
// - Opcodes 0xAA55 or 0xAA56 end configuration outside legacy mode; legacy mode ends on a write to 0xFF.
// - Merge defaults, host and OTP, program hub.
// - OTP wins; OTP hidden from host reads until merge.
// - Set attach enable; hold until VBUS loss, soft disconnect, mode change or reset.
// - Normal mode until host changes mode.
// - Soft disconnect returns to connect stage.
`timescale 1ns/1ps
`default_nettype none
`include "hub_boot_consts.vh"

module hub_boot_sequencer #(
   parameter FLASH_DUAL = 1,
   parameter FLASH_CPOL = 0
) (
   input wire clock,
   input wire rstn,
   input wire pll_lock,
   output reg pll_enable,
   input wire strap_spi_en,
   input wire [2:0] strap_config,
   input wire [3:0] port_disable_plus_straps,
   input wire [3:0] port_disable_minus_straps,
   input wire [2:0] nonremovable_strap,
   input wire [2:0] charge_port_strap,
   input wire legacy_mode,
   output wire spi_cs_n,
   output wire spi_sck,
   output wire spi_mosi_o,
   output wire spi_mosi_oe,
   input wire spi_mosi_i,
   input wire spi_miso_i,
   input wire smb_clk_i,
   input wire smb_dat_i,
   input wire host_wr,
   input wire [7:0] host_addr,
   input wire [7:0] host_wdata,
   input wire [7:0] host_rd_addr,
   output reg [7:0] host_rd_data,
   input wire host_cmd_valid,
   input wire [15:0] host_cmd_opcode,
   output reg [3:0] otp_addr,
   input wire [7:0] otp_data,
   input wire otp_set,
   output reg hub_wr,
   output reg [3:0] hub_addr,
   output reg [7:0] hub_data,
   input wire vbus_det,
   input wire host_configured,
   input wire mode_change,
   input wire soft_disconnect,
   output reg attach_enable,
   output reg keep_serial,
   output reg slave_mode,
   output reg flash_boot,
   output reg [15:0] boot_addr,
   output reg ports_enable,
   output reg usb_pins_oe,
   output reg [3:0] stage
);
   localparam [3:0] ST_STANDBY = 4'h0;
   localparam [3:0] ST_INIT = 4'h1;
   localparam [3:0] ST_FLASH = 4'h2;
   localparam [3:0] ST_ROM = 4'h3;
   localparam [3:0] ST_STRAP = 4'h4;
   localparam [3:0] ST_PROBE = 4'h5;
   localparam [3:0] ST_HOSTCFG = 4'h6;
   localparam [3:0] ST_MERGE = 4'h7;
   localparam [3:0] ST_CONNECT = 4'h8;
   localparam [3:0] ST_NORMAL = 4'h9;
   localparam integer SETTLE_CYC = `PULLUP_SETTLE_CYC;
   localparam [11:0] SETTLE = SETTLE_CYC[11:0];

   reg [1:0] lock_s;
   reg [1:0] spi_en_s;
   reg [1:0] vbus_s;
   reg [1:0] scl_s;
   reg [1:0] sda_s;
   reg [2:0] cfg_s0;
   reg [2:0] cfg_s1;
   reg [13:0] str_s0;
   reg [13:0] str_s1;
   reg [7:0] cfg_r [0:`CFG_ENTRIES-1];
   reg [3:0] idx_r;
   reg ph_r;
   reg [11:0] wait_r;
   reg fl_start_r;
   reg fl_sent_r;
   wire fl_done;
   wire fl_ok;
   wire end_legacy;
   wire end_cmd;
   wire [7:0] merged;
   integer i;

   function [7:0] rom_default;
      input [3:0] idx;
      begin
         case (idx)
            4'h0: rom_default = `ROM_DEF_0;
            4'h1: rom_default = `ROM_DEF_1;
            4'h2: rom_default = `ROM_DEF_2;
            4'h3: rom_default = `ROM_DEF_3;
            4'h4: rom_default = `ROM_DEF_4;
            4'h5: rom_default = `ROM_DEF_5;
            4'h6: rom_default = `ROM_DEF_6;
            4'h7: rom_default = `ROM_DEF_7;
            default: rom_default = `CFG_RESET_VAL;
         endcase
      end
   endfunction

   boot_flash_reader u_flash (
      .clock(clock),
      .rstn(rstn),
      .start(fl_start_r),
      .dual(FLASH_DUAL != 0),
      .cpol(FLASH_CPOL != 0),
      .done(fl_done),
      .sig_ok(fl_ok),
      .spi_cs_n(spi_cs_n),
      .spi_sck(spi_sck),
      .spi_mosi_o(spi_mosi_o),
      .spi_mosi_oe(spi_mosi_oe),
      .spi_mosi_i(spi_mosi_i),
      .spi_miso_i(spi_miso_i)
   );

   // Pins and the PLL lock cross into this domain through two flops.
   always @(posedge clock) begin
      lock_s <= {lock_s[0], pll_lock};
      spi_en_s <= {spi_en_s[0], strap_spi_en};
      vbus_s <= {vbus_s[0], vbus_det};
      scl_s <= {scl_s[0], smb_clk_i};
      sda_s <= {sda_s[0], smb_dat_i};
      cfg_s0 <= strap_config;
      cfg_s1 <= cfg_s0;
      str_s0 <= {port_disable_plus_straps, port_disable_minus_straps,
                 nonremovable_strap, charge_port_strap};
      str_s1 <= str_s0;
   end

   assign end_legacy = legacy_mode && host_wr &&
                       (host_addr == `CFG_END_REG);
   assign end_cmd = !legacy_mode && host_cmd_valid &&
                    ((host_cmd_opcode == `OP_ATTACH) ||
                     (host_cmd_opcode == `OP_ATTACH_KEEP));
   // OTP content takes precedence over whatever the host wrote.
   assign merged = otp_set ? otp_data : cfg_r[idx_r];

   always @(posedge clock) begin
      if (!rstn) begin
         // Nothing survives standby; the whole table is cleared.
         for (i = 0; i < `CFG_ENTRIES; i = i + 1)
            cfg_r[i] <= `CFG_RESET_VAL;
         stage <= ST_STANDBY;
         pll_enable <= 1'b0;
         ports_enable <= 1'b0;
         usb_pins_oe <= 1'b0;
         attach_enable <= 1'b0;
         keep_serial <= 1'b0;
         slave_mode <= 1'b0;
         flash_boot <= 1'b0;
         boot_addr <= `FLASH_EXEC_ADDR;
         host_rd_data <= 8'h00;
         otp_addr <= 4'h0;
         hub_wr <= 1'b0;
         hub_addr <= 4'h0;
         hub_data <= 8'h00;
         idx_r <= 4'h0;
         ph_r <= 1'b0;
         wait_r <= 12'h000;
         fl_start_r <= 1'b0;
         fl_sent_r <= 1'b0;
      end else begin
         hub_wr <= 1'b0;
         fl_start_r <= 1'b0;
         // Host reads see the table only, which holds the OTP values once merged.
         host_rd_data <= (host_rd_addr < `CFG_ENTRIES) ?
                         cfg_r[host_rd_addr[3:0]] : 8'h00;
         case (stage)
            ST_STANDBY: begin
               stage <= ST_INIT;
               idx_r <= 4'h0;
            end
            ST_INIT: begin
               pll_enable <= 1'b1;
               cfg_r[idx_r] <= `CFG_RESET_VAL;
               if (idx_r != 4'hf)
                  idx_r <= idx_r + 4'h1;
               else if (lock_s[1]) begin
                  idx_r <= 4'h0;
                  stage <= spi_en_s[1] ? ST_FLASH : ST_ROM;
               end
            end
            ST_FLASH: begin
               if (!fl_sent_r) begin
                  fl_start_r <= 1'b1;
                  fl_sent_r <= 1'b1;
               end else if (fl_done) begin
                  flash_boot <= fl_ok;
                  boot_addr <= `FLASH_EXEC_ADDR;
                  stage <= ST_ROM;
               end
            end
            ST_ROM: begin
               // Defaults load even when code runs from the flash.
               cfg_r[idx_r] <= rom_default(idx_r);
               idx_r <= idx_r + 4'h1;
               if (idx_r == 4'hf)
                  stage <= ST_STRAP;
            end
            ST_STRAP: begin
               cfg_r[`IDX_PORT_DIS_P] <= {4'h0, str_s1[13:10]};
               cfg_r[`IDX_PORT_DIS_M] <= {4'h0, str_s1[9:6]};
               cfg_r[`IDX_NONREM] <= {5'h00, str_s1[5:3]};
               cfg_r[`IDX_CHARGE] <= {5'h00, str_s1[2:0]};
               cfg_r[`IDX_FUNC_CFG] <= {5'h00, cfg_s1};
               wait_r <= 12'h000;
               idx_r <= 4'h0;
               ph_r <= 1'b0;
               if (cfg_s1 == `FUNC_CFG_SLAVE)
                  stage <= ST_PROBE;
               else
                  stage <= ST_MERGE;
            end
            ST_PROBE: begin
               // Pull-ups are judged only after the pins have settled.
               if (wait_r < SETTLE)
                  wait_r <= wait_r + 12'h001;
               else if (scl_s[1] && sda_s[1]) begin
                  slave_mode <= 1'b1;
                  stage <= ST_HOSTCFG;
               end else
                  stage <= ST_MERGE;
            end
            ST_HOSTCFG: begin
               // No timeout: the stage ends only on the master's word.
               if (end_legacy || end_cmd) begin
                  keep_serial <= end_cmd &&
                                 (host_cmd_opcode == `OP_ATTACH_KEEP);
                  stage <= ST_MERGE;
               end else if (host_wr && host_addr < `CFG_ENTRIES)
                  cfg_r[host_addr[3:0]] <= host_wdata;
            end
            ST_MERGE: begin
               // OTP read has one cycle of latency, hence two phases.
               if (!ph_r) begin
                  otp_addr <= idx_r;
                  ph_r <= 1'b1;
               end else begin
                  cfg_r[idx_r] <= merged;
                  hub_wr <= 1'b1;
                  hub_addr <= idx_r;
                  hub_data <= merged;
                  ph_r <= 1'b0;
                  idx_r <= idx_r + 4'h1;
                  if (idx_r == 4'hf)
                     stage <= ST_CONNECT;
               end
            end
            ST_CONNECT: begin
               // Attach follows VBUS, so a lost supply withdraws it at once.
               attach_enable <= vbus_s[1] && !soft_disconnect;
               ports_enable <= 1'b1;
               usb_pins_oe <= 1'b1;
               if (attach_enable && vbus_s[1] && !soft_disconnect &&
                   host_configured)
                  stage <= ST_NORMAL;
            end
            ST_NORMAL: begin
               if (soft_disconnect || mode_change || !vbus_s[1]) begin
                  attach_enable <= 1'b0;
                  stage <= ST_CONNECT;
               end
            end
            default: stage <= ST_STANDBY;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: shared/hub_boot_consts.vh
// Constants of the hub boot and configuration sequencer.
// Included by bare name from the rtl files; definitions only.
`ifndef HUB_BOOT_CONSTS_VH
`define HUB_BOOT_CONSTS_VH

`define CLK_MHZ 100
`define PULLUP_SETTLE_NS 1000
`define PULLUP_SETTLE_CYC ((`PULLUP_SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define SPI_HALF_CYC 8'h04

`define FLASH_RD_SINGLE 8'h03
`define FLASH_RD_DUAL 8'h3b
`define FLASH_SIG_ADDR 24'h00fffa
`define FLASH_SIG_WORD 32'h32444655
`define FLASH_EXEC_ADDR 16'h0000

`define CFG_END_REG 8'hff
`define OP_ATTACH 16'haa55
`define OP_ATTACH_KEEP 16'haa56
`define FUNC_CFG_SLAVE 3'h5

`define CFG_ENTRIES 16
`define CFG_RESET_VAL 8'h00
`define IDX_PORT_DIS_P 4'h0
`define IDX_PORT_DIS_M 4'h1
`define IDX_NONREM 4'h2
`define IDX_CHARGE 4'h3
`define IDX_FUNC_CFG 4'h4
`define ROM_DEF_0 8'h00
`define ROM_DEF_1 8'h00
`define ROM_DEF_2 8'h00
`define ROM_DEF_3 8'h00
`define ROM_DEF_4 8'h01
`define ROM_DEF_5 8'h24
`define ROM_DEF_6 8'h04
`define ROM_DEF_7 8'h12

`endif

// file: rtl/boot_flash_reader.v
// Reads the four-byte upgrade signature from an external SPI flash.
// Assumes io0/io1 pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "hub_boot_consts.vh"

module boot_flash_reader #(
   parameter [7:0] HALF = `SPI_HALF_CYC
) (
   input wire clock,
   input wire rstn,
   input wire start,
   input wire dual,
   input wire cpol,
   output reg done,
   output reg sig_ok,
   output reg spi_cs_n,
   output wire spi_sck,
   output wire spi_mosi_o,
   output wire spi_mosi_oe,
   input wire spi_mosi_i,
   input wire spi_miso_i
);
   reg [1:0] io0_s;
   reg [1:0] io1_s;
   reg [7:0] div_r;
   reg busy_r;
   reg sck_r;
   reg [6:0] cnt_r;
   reg [31:0] tx_r;
   reg [31:0] rx_r;
   wire tick;
   wire [6:0] last;
   wire [6:0] data_at;

   // Half period must cover the two synchroniser stages on the inputs.
   assign tick = busy_r && (div_r == HALF - 8'h01);
   assign last = dual ? 7'h38 : 7'h40;
   assign data_at = dual ? 7'h28 : 7'h20;
   // Idle level selects clock mode 0 or 3; sampling is on rising edges.
   assign spi_sck = busy_r ? sck_r : cpol;
   assign spi_mosi_o = tx_r[31];
   assign spi_mosi_oe = busy_r && ((cnt_r < 7'h20) || !dual);

   always @(posedge clock) begin
      io0_s <= {io0_s[0], spi_mosi_i};
      io1_s <= {io1_s[0], spi_miso_i};
   end

   always @(posedge clock) begin
      if (!rstn) begin
         done <= 1'b0;
         sig_ok <= 1'b0;
         spi_cs_n <= 1'b1;
         busy_r <= 1'b0;
         sck_r <= 1'b0;
         div_r <= 8'h00;
         cnt_r <= 7'h00;
         tx_r <= 32'h00000000;
         rx_r <= 32'h00000000;
      end else begin
         done <= 1'b0;
         if (start && !busy_r) begin
            busy_r <= 1'b1;
            spi_cs_n <= 1'b0;
            sck_r <= 1'b0;
            div_r <= 8'h00;
            cnt_r <= 7'h00;
            sig_ok <= 1'b0;
            rx_r <= 32'h00000000;
            tx_r <= {(dual ? `FLASH_RD_DUAL : `FLASH_RD_SINGLE),
                     `FLASH_SIG_ADDR};
         end else if (busy_r) begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            if (tick && !sck_r) begin
               sck_r <= 1'b1;
               cnt_r <= cnt_r + 7'h01;
               if (cnt_r >= data_at) begin
                  if (dual)
                     rx_r <= {rx_r[29:0], io1_s[1], io0_s[1]};
                  else
                     rx_r <= {rx_r[30:0], io1_s[1]};
               end
            end else if (tick && cnt_r == last) begin
               busy_r <= 1'b0;
               spi_cs_n <= 1'b1;
               sck_r <= 1'b0;
               done <= 1'b1;
               sig_ok <= (rx_r == `FLASH_SIG_WORD);
            end else if (tick) begin
               sck_r <= 1'b0;
               tx_r <= {tx_r[30:0], 1'b0};
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: bench/hub_boot_chk.sv
// Checker of the boot stage sequencer, bound to its top module.
// Assumes straps and legacy mode stay steady for a whole boot.
`timescale 1ns/1ps
`default_nettype none
`include "hub_boot_consts.vh"
module hub_boot_chk (
   input wire logic clock,
   input wire logic rstn,
   input wire logic strap_spi_en,
   input wire logic [2:0] strap_config,
   input wire logic legacy_mode,
   input wire logic host_wr,
   input wire logic [7:0] host_addr,
   input wire logic host_cmd_valid,
   input wire logic [15:0] host_cmd_opcode,
   input wire logic soft_disconnect,
   input wire logic spi_cs_n,
   input wire logic hub_wr,
   input wire logic attach_enable,
   input wire logic pll_enable,
   input wire logic ports_enable,
   input wire logic [3:0] stage
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   standby_off_a: assert property (disable iff (1'h0)
      !rstn |=> stage == 4'h0 && !pll_enable && !ports_enable
      && !attach_enable && spi_cs_n) else $error("standby not quiet");
   first_stage_a: assert property ($rose(rstn) |=> stage == 4'h1)
      else $error("boot did not start at init");
   stage_order_a: assert property ($changed(stage) |->
      stage == $past(stage) + 4'h1
      || $past(stage) == 4'h9 && stage == 4'h8
      || $past(stage) == 4'h1 && stage == 4'h3
      || ($past(stage) == 4'h4 || $past(stage) == 4'h5) && stage == 4'h7)
      else $error("illegal stage step");
   no_flash_a: assert property ($past(stage) == 4'h1
      && stage != 4'h1 && !strap_spi_en |-> stage == 4'h3)
      else $error("flash probed without strap");
   strap_route_a: assert property (stage == 4'h4 |=>
      stage == (strap_config == `FUNC_CFG_SLAVE ? 4'h5 : 4'h7))
      else $error("wrong stage after straps");
   cs_quiet_a: assert property (stage != 4'h2
      && $past(stage) != 4'h2 |-> spi_cs_n) else $error("flash selected");
   host_wait_a: assert property (stage == 4'h6 && !host_wr
      && !host_cmd_valid |=> stage == 4'h6) else $error("host cfg left");
   opcode_end_a: assert property (stage == 4'h6
      && host_cmd_valid && !legacy_mode && (host_cmd_opcode == `OP_ATTACH
      || host_cmd_opcode == `OP_ATTACH_KEEP) |=> stage == 4'h7)
      else $error("attach opcode not taken");
   legacy_end_a: assert property (stage == 4'h6 && legacy_mode
      && host_wr && host_addr == `CFG_END_REG |=> stage == 4'h7)
      else $error("end register not taken");
   merge_only_a: assert property (hub_wr |-> $past(stage) == 4'h7)
      else $error("hub written outside merge");
   attach_stage_a: assert property ($rose(attach_enable)
      |-> stage == 4'h8) else $error("attach outside connect");
   soft_disc_a: assert property (stage == 4'h9
      && soft_disconnect |=> stage == 4'h8) else $error("disconnect ignored");
endmodule
bind hub_boot_sequencer hub_boot_chk chk (.clock, .rstn, .strap_spi_en,
   .strap_config, .legacy_mode, .host_wr, .host_addr, .host_cmd_valid,
   .host_cmd_opcode, .soft_disconnect, .spi_cs_n, .hub_wr, .attach_enable,
   .pll_enable, .ports_enable, .stage);
`default_nettype wire

// file: bench/flash_model.sv
// Behavioural SPI flash answering the boot signature read.
// Assumes clock mode 0 and the dual read; io0 counts only while the
// sequencer has released it.
`timescale 1ns/1ps
`default_nettype none
`include "hub_boot_consts.vh"
module flash_model (
   input wire logic spi_cs_n,
   input wire logic spi_sck,
   input wire logic spi_mosi_o,
   input wire logic good,
   output logic io0,
   output logic io1
);
   logic [31:0] hdr;
   logic [31:0] sh;
   int n;
   initial begin
      io0 = 1'h0;
      io1 = 1'h1;
      n = 0;
      hdr = '0;
      sh = '0;
   end
   always @(negedge spi_cs_n) n = 0;
   always @(posedge spi_sck) begin
      if (!spi_cs_n) begin
         if (n < 32) hdr = {hdr[30:0], spi_mosi_o};
         n = n + 1;
      end
   end
   // A wrong command or address gets a corrupt word back, so a probe of
   // the wrong place cannot pass.
   always @(negedge spi_sck) begin
      if (!spi_cs_n && n >= 40) begin
         if (n == 40)
            sh = (good && hdr == {`FLASH_RD_DUAL, `FLASH_SIG_ADDR})
               ? `FLASH_SIG_WORD : ~`FLASH_SIG_WORD;
         {io1, io0} = sh[31:30];
         sh = {sh[29:0], 2'h0};
      end
   end
   // Released lines must not keep showing the last bits.
   always @(posedge spi_cs_n) begin
      io0 = ~io0;
      io1 = ~io1;
   end
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench of the boot stage sequencer.
// Assumes the flash model on the SPI pins; the bench plays straps,
// host, OTP and upstream port.
`timescale 1ns/1ps
`default_nettype none
`include "hub_boot_consts.vh"
module testbench;
   logic clock = '0, rstn = '0, strap_spi_en = '0, legacy_mode = '0;
   logic good = '0, smb_dat_i = '0, host_wr = '0, host_cmd_valid = '0;
   logic [2:0] strap_config = '0;
   logic [3:0] port_disable_plus_straps = '0;
   logic [7:0] host_addr = '0, host_wdata = '0, host_rd_addr = '0;
   logic [7:0] otp_data = 8'h3c;
   logic [15:0] host_cmd_opcode = '0;
   logic otp_set = '0, vbus_det = '1, host_configured = '0;
   logic pll_lock = '1, smb_clk_i = '1;
   logic mode_change = '0, soft_disconnect = '0;
   logic [35:0] path;
   logic [7:0] hub_mem [0:15];
   int mismatches = 0, compares = 0, cyc = 0;
   wire spi_cs_n, spi_sck, spi_mosi_o, spi_mosi_oe, io0, spi_miso_i;
   wire hub_wr, attach_enable, keep_serial, slave_mode, flash_boot;
   wire pll_enable, ports_enable, usb_pins_oe;
   wire [7:0] host_rd_data, hub_data;
   wire [3:0] otp_addr, hub_addr, stage;
   wire [15:0] boot_addr;
   wire spi_mosi_i = spi_mosi_oe ? spi_mosi_o : io0;
   hub_boot_sequencer #(.FLASH_DUAL(1), .FLASH_CPOL(0)) dut (.clock, .rstn,
      .pll_lock, .pll_enable, .strap_spi_en, .strap_config,
      .port_disable_plus_straps, .port_disable_minus_straps(4'h6),
      .nonremovable_strap(3'h2), .charge_port_strap(3'h1), .legacy_mode,
      .spi_cs_n, .spi_sck, .spi_mosi_o, .spi_mosi_oe, .spi_mosi_i,
      .spi_miso_i, .smb_clk_i, .smb_dat_i, .host_wr, .host_addr,
      .host_wdata, .host_rd_addr, .host_rd_data, .host_cmd_valid,
      .host_cmd_opcode, .otp_addr, .otp_data, .otp_set, .hub_wr, .hub_addr,
      .hub_data, .vbus_det, .host_configured, .mode_change,
      .soft_disconnect, .attach_enable, .keep_serial, .slave_mode,
      .flash_boot, .boot_addr, .ports_enable, .usb_pins_oe, .stage);
   flash_model fm (.spi_cs_n, .spi_sck, .spi_mosi_o, .good, .io0,
      .io1(spi_miso_i));
   always #5 clock = ~clock;
   always @(posedge clock) begin
      if (!rstn) begin
         path <= '0;
         foreach (hub_mem[i]) hub_mem[i] <= 8'hee;
      end else begin
         if (stage != path[3:0]) path <= {path[31:0], stage};
         if (hub_wr) hub_mem[hub_addr] <= hub_data;
      end
      cyc = cyc + 1;
      if (cyc == 20000) begin
         mismatches = mismatches + 1;
         report_and_stop;
      end
   end
   // Only entry 3 is burnt into OTP, so it must beat the host value.
   always @(negedge clock) otp_set <= otp_addr == 4'h3;
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic boot(input logic s, g, input logic [2:0] c,
         input logic d, lg);
      @(negedge clock);
      rstn = 1'h0;
      {strap_spi_en, good, strap_config, smb_dat_i, legacy_mode} =
         {s, g, c, d, lg};
      port_disable_plus_straps = {1'h1, c};
      host_configured = 1'h0;
      step(20);
      chk({stage, attach_enable, keep_serial, slave_mode, flash_boot,
         pll_enable, ports_enable, usb_pins_oe}, 11'h000);
      rstn = 1'h1;
      for (int i = 0; i < 3000 && stage != 4'h6 && stage != 4'h8; i++)
         step(1);
   endtask
   task automatic wr(input logic [7:0] a, d);
      {host_addr, host_wdata, host_wr} = {a, d, 1'h1};
      step(1);
      host_wr = 1'h0;
      step(1);
   endtask
   task automatic cmd(input logic [15:0] op);
      {host_cmd_opcode, host_cmd_valid} = {op, 1'h1};
      step(1);
      host_cmd_valid = 1'h0;
      step(1);
   endtask
   task automatic rd(input logic [7:0] a, e);
      host_rd_addr = a;
      step(2);
      chk(host_rd_data, e);
   endtask
   task automatic attach(input logic [35:0] p);
      for (int i = 0; i < 200 && stage != 4'h8; i++) step(1);
      for (int i = 0; i < 10 && attach_enable !== 1'h1; i++) step(1);
      chk(attach_enable, 1'h1);
      chk({pll_enable, ports_enable, usb_pins_oe}, 3'h7);
      host_configured = 1'h1;
      step(3);
      chk(path, p);
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      boot(1'h1, 1'h1, 3'h5, 1'h1, 1'h0);
      chk({stage, flash_boot, slave_mode}, 6'h1b);
      chk(boot_addr, `FLASH_EXEC_ADDR);
      wr(8'h02, 8'h5a);
      wr(8'h03, 8'ha5);
      rd(8'h03, 8'ha5);
      rd(8'h20, 8'h00);
      cmd(16'h1234);
      chk(stage, 4'h6);
      cmd(`OP_ATTACH_KEEP);
      attach(36'h123456789);
      chk({keep_serial, hub_mem[0], hub_mem[2]}, 17'h10d5a);
      chk({hub_mem[3], hub_mem[7]}, {8'h3c, `ROM_DEF_7});
      soft_disconnect = 1'h1;
      step(3);
      chk(stage, 4'h8);
      soft_disconnect = 1'h0;
      step(5);
      chk(stage, 4'h9);
      {host_configured, mode_change} = 2'h1;
      step(1);
      mode_change = 1'h0;
      step(3);
      chk(stage, 4'h8);
      vbus_det = 1'h0;
      step(5);
      chk({stage, attach_enable}, 5'h10);
      vbus_det = 1'h1;
      $display("test 1 done");
      boot(1'h1, 1'h0, 3'h3, 1'h1, 1'h0);
      attach(36'h1234789);
      chk({flash_boot, hub_mem[2], hub_mem[1]},
         {1'h0, 8'h02, 8'h06});
      $display("test 2 done");
      boot(1'h0, 1'h1, 3'h5, 1'h1, 1'h1);
      cmd(`OP_ATTACH);
      chk(stage, 4'h6);
      wr(`CFG_END_REG, 8'h00);
      attach(36'h13456789);
      $display("test 3 done");
      boot(1'h0, 1'h1, 3'h5, 1'h1, 1'h0);
      cmd(`OP_ATTACH);
      attach(36'h13456789);
      chk(keep_serial, 1'h0);
      $display("test 4 done");
      pll_lock = 1'h0;
      smb_clk_i = 1'h0;
      boot(1'h0, 1'h1, 3'h5, 1'h1, 1'h0);
      chk({stage, pll_enable}, 5'h03);
      pll_lock = 1'h1;
      attach(36'h1345789);
      chk(slave_mode, 1'h0);
      $display("test 5 done");
      report_and_stop;
   end
endmodule
`default_nettype wire
